// ===== src/svce_engine.sv
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module svce_engine
   import svce_pkg::*;
#(
   parameter int BLK_BYTES = BLK_BYTES_DEF
)(
   // clock, reset, enable
   input wire logic I_CLOCK,
   input wire logic I_RST,
   input wire logic I_CE,
   // command block bytes from the initiator side
   input wire logic I_CDB_VALID,
   input wire logic [7:0] I_CDB_BYTE,
   output logic O_CDB_READY,
   // data-out bytes from the initiator
   input wire logic I_DOUT_VALID,
   input wire logic [7:0] I_DOUT_BYTE,
   output logic O_DOUT_READY,
   // medium read port
   output logic O_MED_REQ,
   output logic [31:0] O_MED_LBA,
   output logic O_MED_FUA,
   output logic O_MED_NO_CACHE,
   input wire logic I_MED_VALID,
   input wire logic [7:0] I_MED_BYTE,
   input wire logic I_MED_ECC_ERR,
   output logic O_MED_READY,
   // completion status
   output logic O_BUSY,
   output logic O_DONE,
   output logic O_CHECK,
   output logic [3:0] O_SENSE_KEY,
   output logic [7:0] O_ASC,
   output logic [7:0] O_ASCQ,
   output logic [31:0] O_INFO_LBA,
   // register port
   input wire logic [3:0] I_REG_ADDR,
   input wire logic [31:0] I_REG_WDATA,
   input wire logic I_REG_WR,
   input wire logic I_REG_RD,
   output logic [31:0] O_REG_RDATA
);
   localparam int BLEN = BLK_BYTES + int'(PI_BYTES);
   localparam logic [15:0] USER_LAST = 16'(BLK_BYTES - 1);
   localparam logic [15:0] BLK_LAST = 16'(BLEN - 1);

   typedef struct packed {
      svce_state_t st;
      logic [3:0] idx;
      logic [3:0] cdb_len;
      logic [11:0][7:0] cdb;
      logic [31:0] lba;
      logic [31:0] left;
      logic [2:0] vp;
      logic bchk;
      logic [15:0] pos;
      logic [15:0] crc;
      logic [15:0] grd_rx;
      logic [31:0] ref_rx;
      logic ecc_bad;
      logic cmp_bad;
      logic med_req;
      logic done;
      logic check;
      logic [3:0] key;
      logic [7:0] asc;
      logic [7:0] ascq;
      logic [31:0] info;
      logic prot_fmt;
      logic [31:0] rdata;
   } svce_regs_t;

   svce_regs_t r;
   svce_regs_t nxt;

   logic dec_known;
   logic [2:0] dec_vp;
   logic dec_bchk;
   logic [31:0] dec_lba;
   logic [31:0] dec_len;
   logic dec_rsv_bad;
   logic [15:0] crc_step;

   ////////////////////////////////////////////////////////////////////////////
   svce_cdb u_cdb (
      .i_cdb(r.cdb),
      .o_known(dec_known),
      .o_vp(dec_vp),
      .o_bchk(dec_bchk),
      .o_lba(dec_lba),
      .o_len(dec_len),
      .o_rsv_bad(dec_rsv_bad)
   );

   svce_guard u_guard (
      .i_crc(r.crc),
      .i_byte(I_MED_BYTE),
      .o_crc(crc_step)
   );

   ////////////////////////////////////////////////////////////////////////////
   logic in_xfer;
   logic take;
   logic is_user;
   logic [15:0] pi_pos;
   logic pi_cmp;
   logic do_int;
   logic chk_grd;
   logic chk_ref;
   logic prot_blk;

   assign in_xfer = r.st == ST_XFER;
   // readies drop while the block is frozen: the far side would otherwise
   // count a byte that the held state never took
   // with bytechk the two streams move in lock step, one byte pair a cycle
   assign O_MED_READY = in_xfer & I_CE & (~r.bchk | I_DOUT_VALID);
   assign O_DOUT_READY = in_xfer & I_CE & r.bchk & I_MED_VALID;
   assign take = in_xfer & I_MED_VALID & (~r.bchk | I_DOUT_VALID);
   assign O_CDB_READY = I_CE & ((r.st == ST_IDLE) | (r.st == ST_CDB));
   assign prot_blk = r.prot_fmt;
   assign is_user = r.pos <= USER_LAST;
   assign pi_pos = r.pos - 16'(BLK_BYTES);

   // host-side compare of protection bytes follows the protect select
   always_comb begin
      pi_cmp = 1'b0;
      if (pi_pos <= 16'(PI_GRD_END)) begin
         pi_cmp = (r.vp == VP_FULL) | (r.vp == VP_GRD);
      end else if (pi_pos > 16'(PI_APP_END)) begin
         pi_cmp = (r.vp == VP_FULL) | (r.vp == VP_NOGRD);
      end
   end

   // internal checking on a protected medium: always without bytechk, only select zero with it
   assign do_int = prot_blk & (~r.bchk | (r.vp == VP_ALL));
   assign chk_grd = do_int & ((r.vp == VP_ALL) | (r.vp == VP_FULL) | (r.vp == VP_GRD));
   assign chk_ref = do_int & ((r.vp == VP_ALL) | (r.vp == VP_FULL) | (r.vp == VP_NOGRD));

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt = r;
      nxt.med_req = 1'b0;
      nxt.done = 1'b0;

      // register port: reads answer one cycle later, unmapped reads zero
      if (I_REG_WR && I_REG_ADDR == REG_CTRL) begin
         nxt.prot_fmt = I_REG_WDATA[CTRL_PROT];
      end
      if (I_REG_RD) begin
         case (I_REG_ADDR)
            REG_CTRL: nxt.rdata = {31'h0, r.prot_fmt};
            REG_STAT: nxt.rdata = {8'h00, r.ascq, r.asc, r.key, 2'h0, r.check,
               (r.st != ST_IDLE)};
            REG_INFO: nxt.rdata = r.info;
            default: nxt.rdata = 32'h0;
         endcase
      end

      case (r.st)
         ST_IDLE: begin
            if (I_CDB_VALID) begin
               nxt.cdb = '0;
               nxt.cdb[B_OPC] = I_CDB_BYTE;
               nxt.idx = 4'h1;
               nxt.check = 1'b0;
               nxt.key = SK_NONE;
               nxt.asc = ASC_NONE;
               nxt.ascq = ASCQ_NONE;
               if (I_CDB_BYTE == OPC_VERIFY10) begin
                  nxt.cdb_len = CDB_LEN10;
                  nxt.st = ST_CDB;
               end else if (I_CDB_BYTE == OPC_VERIFY12) begin
                  nxt.cdb_len = CDB_LEN12;
                  nxt.st = ST_CDB;
               end else begin
                  // unknown code is judged at once; no further bytes are taken
                  nxt.st = ST_DEC;
               end
            end
         end
         ST_CDB: begin
            if (I_CDB_VALID) begin
               nxt.cdb[r.idx] = I_CDB_BYTE;
               nxt.idx = r.idx + 4'h1;
               if (r.idx == r.cdb_len - 4'h1) begin
                  nxt.st = ST_DEC;
               end
            end
         end
         ST_DEC: begin
            // info points at the first block until an error or the next block
            nxt.lba = dec_lba;
            nxt.left = dec_len;
            nxt.vp = dec_vp;
            nxt.bchk = dec_bchk;
            nxt.info = dec_lba;
            nxt.st = ST_FIN;
            if (!dec_known) begin
               nxt.check = 1'b1;
               nxt.key = SK_ILLEGAL;
               nxt.asc = ASC_BAD_OPC;
            end else if (dec_rsv_bad || dec_vp > VP_GRD ||
                         (dec_vp != VP_ALL && !r.prot_fmt)) begin
               nxt.check = 1'b1;
               nxt.key = SK_ILLEGAL;
               nxt.asc = ASC_BAD_FIELD;
            end else if (dec_len != 32'h0) begin
               nxt.st = ST_REQ;
            end
         end
         ST_REQ: begin
            nxt.med_req = 1'b1;
            nxt.pos = 16'h0;
            nxt.crc = GUARD_INIT;
            nxt.ecc_bad = 1'b0;
            nxt.cmp_bad = 1'b0;
            nxt.st = ST_XFER;
         end
         ST_XFER: begin
            // faults are only gathered here; the verdict waits for the block end
            if (take) begin
               nxt.pos = r.pos + 16'h1;
               if (I_MED_ECC_ERR) begin
                  nxt.ecc_bad = 1'b1;
               end
               if (is_user) begin
                  nxt.crc = crc_step;
                  if (r.bchk && I_DOUT_BYTE != I_MED_BYTE) begin
                     nxt.cmp_bad = 1'b1;
                  end
               end else begin
                  if (pi_pos <= 16'(PI_GRD_END)) begin
                     nxt.grd_rx = {r.grd_rx[7:0], I_MED_BYTE};
                  end
                  nxt.ref_rx = {r.ref_rx[23:0], I_MED_BYTE};
                  if (r.bchk && pi_cmp && I_DOUT_BYTE != I_MED_BYTE) begin
                     nxt.cmp_bad = 1'b1;
                  end
               end
               // protection bytes exist only on a protected medium
               if (r.pos == (prot_blk ? BLK_LAST : USER_LAST)) begin
                  nxt.st = ST_EVAL;
               end
            end
         end
         ST_EVAL: begin
            // medium error outranks miscompare, which outranks field checks
            if (r.ecc_bad) begin
               nxt.check = 1'b1;
               nxt.key = SK_MEDIUM;
               nxt.asc = ASC_READ_ERR;
            end else if (r.cmp_bad) begin
               nxt.check = 1'b1;
               nxt.key = SK_MISCOMPARE;
               nxt.asc = ASC_MISCOMPARE;
            end else if (chk_grd && r.grd_rx != r.crc) begin
               nxt.check = 1'b1;
               nxt.key = SK_ABORTED;
               nxt.asc = ASC_PI;
               nxt.ascq = ASCQ_GRD;
            end else if (chk_ref && r.ref_rx != r.lba) begin
               nxt.check = 1'b1;
               nxt.key = SK_ABORTED;
               nxt.asc = ASC_PI;
               nxt.ascq = ASCQ_REF;
            end
            if (r.ecc_bad || r.cmp_bad || (chk_grd && r.grd_rx != r.crc) ||
                (chk_ref && r.ref_rx != r.lba)) begin
               // the failing address stays for the host to restart after
               nxt.info = r.lba;
               nxt.st = ST_FIN;
            end else if (r.left == 32'h1) begin
               nxt.st = ST_FIN;
            end else begin
               nxt.lba = r.lba + 32'h1;
               nxt.info = r.lba + 32'h1;
               nxt.left = r.left - 32'h1;
               nxt.st = ST_REQ;
            end
         end
         ST_FIN: begin
            nxt.done = 1'b1;
            nxt.st = ST_IDLE;
         end
         default: begin
            nxt.st = ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         r <= '0;
         r.st <= ST_IDLE;
         r.prot_fmt <= CTRL_PROT_RST;
      end else if (I_CE) begin
         r <= nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign O_MED_REQ = r.med_req;
   assign O_MED_LBA = r.lba;
   // no cached copy is ever trusted or filled, so dpo needs no handling
   assign O_MED_FUA = 1'b1;
   assign O_MED_NO_CACHE = 1'b1;
   assign O_BUSY = r.st != ST_IDLE;
   assign O_DONE = r.done;
   assign O_CHECK = r.check;
   assign O_SENSE_KEY = r.key;
   assign O_ASC = r.asc;
   assign O_ASCQ = r.ascq;
   assign O_INFO_LBA = r.info;
   assign O_REG_RDATA = r.rdata;
endmodule : svce_engine
`default_nettype wire

// ===== src/svce_pkg.sv
package svce_pkg;
   // command codes
   localparam logic [7:0] OPC_VERIFY10 = 8'h2F;
   localparam logic [7:0] OPC_VERIFY12 = 8'hAF;
   localparam logic [3:0] CDB_LEN10 = 4'hA;
   localparam logic [3:0] CDB_LEN12 = 4'hC;
   // byte positions inside the command block
   localparam int B_OPC = 0;
   localparam int B_FLG = 1;
   localparam int B_LBA = 2;
   localparam int B_RSV10 = 6;
   localparam int B_LEN10 = 7;
   localparam int B_CTL10 = 9;
   localparam int B_LEN12 = 6;
   localparam int B_RSV12 = 10;
   localparam int B_CTL12 = 11;
   // bit positions in the flag byte
   localparam int F_VP_HI = 7;
   localparam int F_VP_LO = 5;
   localparam int F_DPO = 4;
   localparam int F_FUA = 3;
   localparam int F_RSV2 = 2;
   localparam int F_BCHK = 1;
   localparam int F_RSV0 = 0;
   // control byte: vendor bits 7:6 and reserved bits 5:2 must be zero
   localparam int CTL_RSV_LO = 2;
   // protection select values
   localparam logic [2:0] VP_ALL = 3'h0;
   localparam logic [2:0] VP_FULL = 3'h1;
   localparam logic [2:0] VP_NOGRD = 3'h2;
   localparam logic [2:0] VP_NONE = 3'h3;
   localparam logic [2:0] VP_GRD = 3'h4;
   // protection bytes that trail each block: guard 0-1, app tag 2-3, ref tag 4-7
   localparam logic [3:0] PI_BYTES = 4'h8;
   localparam logic [3:0] PI_GRD_END = 4'h1;
   localparam logic [3:0] PI_APP_END = 4'h3;
   localparam logic [15:0] GUARD_POLY = 16'h8BB7;
   localparam logic [15:0] GUARD_INIT = 16'h0000;
   // sense keys and codes
   localparam logic [3:0] SK_NONE = 4'h0;
   localparam logic [3:0] SK_MEDIUM = 4'h3;
   localparam logic [3:0] SK_ILLEGAL = 4'h5;
   localparam logic [3:0] SK_ABORTED = 4'hB;
   localparam logic [3:0] SK_MISCOMPARE = 4'hE;
   localparam logic [7:0] ASC_NONE = 8'h00;
   localparam logic [7:0] ASC_READ_ERR = 8'h11;
   localparam logic [7:0] ASC_MISCOMPARE = 8'h1D;
   localparam logic [7:0] ASC_BAD_OPC = 8'h20;
   localparam logic [7:0] ASC_BAD_FIELD = 8'h24;
   localparam logic [7:0] ASC_PI = 8'h10;
   localparam logic [7:0] ASCQ_NONE = 8'h00;
   localparam logic [7:0] ASCQ_GRD = 8'h01;
   localparam logic [7:0] ASCQ_REF = 8'h03;
   // register map (byte addresses) and reset values
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h4;
   localparam logic [3:0] REG_INFO = 4'h8;
   localparam int CTRL_PROT = 0;
   localparam logic CTRL_PROT_RST = 1'b0;
   localparam int BLK_BYTES_DEF = 512;
   typedef enum logic [2:0] {
      ST_IDLE, ST_CDB, ST_DEC, ST_REQ, ST_XFER, ST_EVAL, ST_FIN
   } svce_state_t;
endpackage : svce_pkg

// ===== src/svce_guard.sv
`timescale 1ns/1ns
`default_nettype none
// one byte step of the guard crc, msb first, no reflection
module svce_guard
   import svce_pkg::*;
(
   input wire logic [15:0] i_crc,
   input wire logic [7:0] i_byte,
   output logic [15:0] o_crc
);
   logic [15:0] chain [0:8];
   assign chain[0] = i_crc;
   for (genvar i = 0; i < 8; i++) begin : g_bit
      assign chain[i+1] = {chain[i][14:0], 1'b0} ^
         ((chain[i][15] ^ i_byte[7-i]) ? GUARD_POLY : 16'h0000);
   end
   assign o_crc = chain[8];
endmodule : svce_guard
`default_nettype wire

// ===== src/svce_cdb.sv
`timescale 1ns/1ns
`default_nettype none
// field split of a stored command block, byte 0 at index 0
module svce_cdb
   import svce_pkg::*;
(
   input wire logic [11:0][7:0] i_cdb,
   output logic o_known,
   output logic [2:0] o_vp,
   output logic o_bchk,
   output logic [31:0] o_lba,
   output logic [31:0] o_len,
   output logic o_rsv_bad
);
   logic is10;
   logic is12;
   logic [7:0] flg;
   logic [7:0] ctl;
   assign is10 = i_cdb[B_OPC] == OPC_VERIFY10;
   assign is12 = i_cdb[B_OPC] == OPC_VERIFY12;
   assign o_known = is10 | is12;
   assign flg = i_cdb[B_FLG];
   assign o_vp = flg[F_VP_HI:F_VP_LO];
   assign o_bchk = flg[F_BCHK];
   assign o_lba = {i_cdb[B_LBA], i_cdb[B_LBA+1], i_cdb[B_LBA+2], i_cdb[B_LBA+3]};
   assign o_len = is10 ? {16'h0000, i_cdb[B_LEN10], i_cdb[B_LEN10+1]} :
      {i_cdb[B_LEN12], i_cdb[B_LEN12+1], i_cdb[B_LEN12+2], i_cdb[B_LEN12+3]};
   assign ctl = is10 ? i_cdb[B_CTL10] : i_cdb[B_CTL12];
   // dpo is legal in either form, fua only in the 12-byte form; neither carries meaning here
   assign o_rsv_bad = flg[F_RSV0] | (ctl[7:CTL_RSV_LO] != 6'h00) |
      (is10 ? (flg[F_FUA] | flg[F_RSV2] | (i_cdb[B_RSV10] != 8'h00)) :
              (flg[F_RSV2] | (i_cdb[B_RSV12] != 8'h00)));
endmodule : svce_cdb
`default_nettype wire

// ===== sim/svce_engine_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module svce_chk
   import svce_pkg::*;
(
   input wire logic I_CLOCK,
   input wire logic I_RST,
   input wire logic I_CE,
   input wire logic I_CDB_VALID,
   input wire logic O_CDB_READY,
   input wire logic I_DOUT_VALID,
   input wire logic O_DOUT_READY,
   input wire logic O_MED_REQ,
   input wire logic O_MED_FUA,
   input wire logic O_MED_NO_CACHE,
   input wire logic I_MED_VALID,
   input wire logic O_MED_READY,
   input wire logic O_BUSY,
   input wire logic O_DONE,
   input wire logic O_CHECK,
   input wire logic [3:0] O_SENSE_KEY,
   input wire logic [7:0] O_ASC,
   input wire logic [7:0] O_ASCQ,
   input wire logic [31:0] O_INFO_LBA,
   input wire logic [3:0] I_REG_ADDR,
   input wire logic I_REG_RD,
   input wire logic [31:0] O_REG_RDATA
);
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (I_RST);
   fixed_access_a: assert property (O_MED_FUA && O_MED_NO_CACHE)
      else $error("medium access not forced past cache");
   req_busy_a: assert property (O_MED_REQ |-> O_BUSY && !O_CDB_READY)
      else $error("block request outside a command");
   req_pulse_a: assert property (O_MED_REQ |=> !O_MED_REQ)
      else $error("block request longer than one cycle");
   done_pulse_a: assert property (O_DONE |=> !O_DONE)
      else $error("done longer than one cycle");
   done_idle_a: assert property (O_DONE |-> !O_BUSY && O_CDB_READY == I_CE)
      else $error("done while still busy");
   byte_pair_a: assert property (O_DOUT_READY && I_DOUT_VALID |-> O_MED_READY && I_MED_VALID)
      else $error("host byte taken without medium byte");
   check_key_a: assert property (O_DONE |-> O_CHECK == (O_SENSE_KEY != SK_NONE))
      else $error("check flag disagrees with sense key");
   sense_hold_a: assert property (!O_BUSY && !I_CDB_VALID |=> $stable(O_SENSE_KEY) && $stable(O_CHECK))
      else $error("status changed while idle");
   ecc_code_a: assert property (O_DONE && O_SENSE_KEY == SK_MEDIUM |-> O_ASC == ASC_READ_ERR)
      else $error("medium error with wrong code");
   stat_read_a: assert property (I_REG_RD && I_REG_ADDR == REG_STAT |=> O_REG_RDATA ==
      {8'h00, $past(O_ASCQ), $past(O_ASC), $past(O_SENSE_KEY), 2'b00, $past(O_CHECK), $past(O_BUSY)})
      else $error("status word read wrong");
   info_read_a: assert property (I_REG_RD && I_REG_ADDR == REG_INFO |=> O_REG_RDATA == $past(O_INFO_LBA))
      else $error("failing address read wrong");
   unmapped_read_a: assert property (I_REG_RD && I_REG_ADDR == 4'hC |=> O_REG_RDATA == 32'h0)
      else $error("unmapped read not zero");
endmodule : svce_chk
bind svce_engine svce_chk u_chk (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_CE(I_CE),
   .I_CDB_VALID(I_CDB_VALID), .O_CDB_READY(O_CDB_READY), .I_DOUT_VALID(I_DOUT_VALID),
   .O_DOUT_READY(O_DOUT_READY),
   .O_MED_REQ(O_MED_REQ), .O_MED_FUA(O_MED_FUA), .O_MED_NO_CACHE(O_MED_NO_CACHE),
   .I_MED_VALID(I_MED_VALID), .O_MED_READY(O_MED_READY), .O_BUSY(O_BUSY), .O_DONE(O_DONE),
   .O_CHECK(O_CHECK), .O_SENSE_KEY(O_SENSE_KEY), .O_ASC(O_ASC), .O_ASCQ(O_ASCQ),
   .O_INFO_LBA(O_INFO_LBA), .I_REG_ADDR(I_REG_ADDR), .I_REG_RD(I_REG_RD), .O_REG_RDATA(O_REG_RDATA));
`default_nettype wire

// ===== sim/svce_medium.sv
`timescale 1ns/1ns
`default_nettype none
// behavioural medium: streams a block per request, can stall and inject faults
module svce_medium
   import svce_pkg::*;
#(
   parameter int BLK = 4
)(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_req,
   input wire logic [31:0] i_lba,
   input wire logic i_ready,
   input wire logic i_prot,
   input wire logic i_slow,
   input wire logic [1:0] i_kind,
   input wire logic [31:0] i_elba,
   output logic o_valid,
   output logic [7:0] o_byte,
   output logic o_ecc
);
   logic act = 1'b0;
   logic [31:0] lba = 32'h0;
   int idx = 0;
   function automatic logic [7:0] pat(input logic [31:0] l, input int i);
      return l[7:0] ^ 8'h5A ^ 8'(i * 29);
   endfunction : pat
   function automatic logic [7:0] mb(input logic [31:0] l, input int i);
      logic [15:0] c;
      logic [63:0] pi;
      c = GUARD_INIT;
      if (i < BLK) return pat(l, i);
      for (int j = 0; j < BLK; j++) begin
         c = c ^ {pat(l, j), 8'h00};
         for (int b = 0; b < 8; b++) c = c[15] ? ((c << 1) ^ GUARD_POLY) : (c << 1);
      end
      // guard and ref faults go into the stored tags so only an enabled check sees them
      pi = {c ^ 16'(i_kind == 2'd2 && l == i_elba), 16'h0000,
         l ^ 32'(i_kind == 2'd3 && l == i_elba)};
      return pi[63 - 8 * (i - BLK) -: 8];
   endfunction : mb
   assign o_ecc = act && i_kind == 2'd1 && lba == i_elba;
   always @(posedge i_clk) begin
      if (i_rst) begin
         act <= 1'b0;
         o_valid <= 1'b0;
      end else if (i_req) begin
         act <= 1'b1;
         lba <= i_lba;
         idx <= 0;
         o_valid <= !i_slow;
         o_byte <= i_slow ? ~mb(i_lba, 0) : mb(i_lba, 0);
      end else if (act && o_valid && i_ready) begin
         act <= (idx + 1) != BLK + (i_prot ? 8 : 0);
         idx <= idx + 1;
         o_valid <= !i_slow && (idx + 1) != BLK + (i_prot ? 8 : 0);
         o_byte <= i_slow ? ~o_byte : mb(lba, idx + 1);
      end else if (act && !o_valid) begin
         o_valid <= 1'b1;
         o_byte <= mb(lba, idx);
      end else if (!act) begin
         o_byte <= ~o_byte;
      end
   end
endmodule : svce_medium
`default_nettype wire

// ===== sim/svce_engine_tb.sv
`timescale 1ns/1ns
`default_nettype none
module svce_engine_tb
   import svce_pkg::*;
;
   localparam int BLK = 4;
   logic I_CLOCK, I_RST, I_CDB_VALID, I_DOUT_VALID, I_MED_VALID, I_MED_ECC_ERR, I_REG_WR, I_REG_RD;
   logic [7:0] I_CDB_BYTE, I_DOUT_BYTE, I_MED_BYTE, O_ASC, O_ASCQ;
   logic [3:0] I_REG_ADDR, O_SENSE_KEY;
   logic [31:0] I_REG_WDATA, O_REG_RDATA, O_MED_LBA, O_INFO_LBA, st, e_lba, a, r;
   logic O_CDB_READY, O_DOUT_READY, O_MED_REQ, O_MED_READY, O_BUSY, O_DONE, O_CHECK, prot, slow;
   logic [1:0] e_kind;
   int n_errors = 0, checks_done = 0, n_req = 0, k = 0, bad_k = -1, hit;
   logic [3:0] b4 [4] = '{REG_CTRL, REG_STAT, REG_INFO, 4'hC};
   logic [7:0] bad_flags [4] = '{8'h01, 8'h04, 8'h04, 8'h00};
   svce_engine #(.BLK_BYTES(BLK)) dut (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_CE(1'b1),
      .I_CDB_VALID(I_CDB_VALID), .I_CDB_BYTE(I_CDB_BYTE), .O_CDB_READY(O_CDB_READY),
      .I_DOUT_VALID(I_DOUT_VALID), .I_DOUT_BYTE(I_DOUT_BYTE), .O_DOUT_READY(O_DOUT_READY),
      .O_MED_REQ(O_MED_REQ), .O_MED_LBA(O_MED_LBA), .O_MED_FUA(), .O_MED_NO_CACHE(),
      .I_MED_VALID(I_MED_VALID), .I_MED_BYTE(I_MED_BYTE), .I_MED_ECC_ERR(I_MED_ECC_ERR),
      .O_MED_READY(O_MED_READY), .O_BUSY(O_BUSY), .O_DONE(O_DONE), .O_CHECK(O_CHECK),
      .O_SENSE_KEY(O_SENSE_KEY), .O_ASC(O_ASC), .O_ASCQ(O_ASCQ), .O_INFO_LBA(O_INFO_LBA),
      .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA), .I_REG_WR(I_REG_WR),
      .I_REG_RD(I_REG_RD), .O_REG_RDATA(O_REG_RDATA));
   svce_medium #(.BLK(BLK)) u_med (.i_clk(I_CLOCK), .i_rst(I_RST), .i_req(O_MED_REQ),
      .i_lba(O_MED_LBA), .i_ready(O_MED_READY), .i_prot(prot), .i_slow(slow), .i_kind(e_kind),
      .i_elba(e_lba), .o_valid(I_MED_VALID), .o_byte(I_MED_BYTE), .o_ecc(I_MED_ECC_ERR));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] dbyte(input int i);
      logic [31:0] l;
      l = st + i / BLK;
      return l[7:0] ^ 8'h5A ^ 8'((i % BLK) * 29) ^ ((i == bad_k) ? 8'h01 : 8'h00);
   endfunction : dbyte
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   task automatic reg_wr(input logic [3:0] ad, input logic [31:0] d);
      I_REG_ADDR <= ad;
      I_REG_WDATA <= d;
      I_REG_WR <= 1'b1;
      @(posedge I_CLOCK);
      I_REG_WR <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [3:0] ad, output logic [31:0] d);
      I_REG_ADDR <= ad;
      I_REG_RD <= 1'b1;
      @(posedge I_CLOCK);
      I_REG_RD <= 1'b0;
      @(negedge I_CLOCK);
      d = O_REG_RDATA;
      @(posedge I_CLOCK);
   endtask : reg_rd
   // one command end to end; expected status and number of block reads given by caller
   task automatic cmd(input logic [7:0] opc, input logic [7:0] flg, input logic [31:0] lba,
      input logic [31:0] len, input logic [7:0] ctl, input logic [3:0] ek, input logic [7:0] ea,
      input logic [7:0] eq, input int nr);
      logic [7:0] b [12];
      int n;
      b = '{opc, flg, lba[31:24], lba[23:16], lba[15:8], lba[7:0], 8'h00, len[15:8], len[7:0],
         ctl, 8'h00, 8'h00};
      n = 10;
      if (opc == OPC_VERIFY12) begin
         n = 12;
         {b[6], b[7], b[8], b[9]} = len;
         b[9 + 2] = ctl;
      end else if (opc != OPC_VERIFY10) begin
         // an unknown code is judged on byte 0 alone
         n = 1;
      end
      st = lba;
      k = 0;
      n_req = 0;
      I_DOUT_BYTE <= dbyte(0);
      I_DOUT_VALID <= flg[F_BCHK];
      for (int i = 0; i < n; i++) begin
         I_CDB_VALID <= 1'b1;
         I_CDB_BYTE <= b[i];
         @(posedge I_CLOCK);
      end
      I_CDB_VALID <= 1'b0;
      for (int t = 0; t < 3000 && O_DONE !== 1'b1; t++) @(negedge I_CLOCK);
      chk(O_DONE, 1'b1);
      chk(O_SENSE_KEY, ek);
      chk(O_ASC, ea);
      chk(O_ASCQ, eq);
      chk(O_CHECK, ek != SK_NONE);
      chk(n_req, nr);
      if (ek inside {SK_MEDIUM, SK_MISCOMPARE, SK_ABORTED}) chk(O_INFO_LBA, e_lba);
      @(posedge I_CLOCK);
      I_DOUT_VALID <= 1'b0;
      @(posedge I_CLOCK);
      $display("command %h at %h count %0d finished at %0t", opc, lba, len, $time);
   endtask : cmd
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge I_CLOCK) if (I_DOUT_VALID && O_DOUT_READY) begin
      k = k + 1;
      I_DOUT_BYTE <= dbyte(k);
   end
   always @(posedge I_CLOCK) if (O_MED_REQ) n_req = n_req + 1;
   initial begin
      I_CLOCK = 1'b0;
      forever #20 I_CLOCK = ~I_CLOCK;
   end
   initial begin
      repeat (20000) @(posedge I_CLOCK);
      n_errors++;
      print_verdict();
   end
   initial begin
      {I_CDB_VALID, I_DOUT_VALID, I_REG_WR, I_REG_RD, prot, slow} = '0;
      {I_CDB_BYTE, I_DOUT_BYTE, I_REG_ADDR, I_REG_WDATA, e_kind, e_lba} = '0;
      I_RST = 1'b1;
      void'($urandom(13));
      repeat (2) @(posedge I_CLOCK);
      I_RST <= 1'b0;
      @(posedge I_CLOCK);
      foreach (b4[i]) begin
         reg_rd(b4[i], r);
         chk(r, 32'h0);
      end
      reg_wr(4'hC, 32'hFFFFFFFF);
      reg_rd(4'hC, r);
      chk(r, 32'h0);
      for (int vp = 0; vp < 8; vp++) begin
         hit = (vp != 0);
         cmd(OPC_VERIFY10, 8'(vp << 5), $urandom, 1, 8'h00, hit ? SK_ILLEGAL : SK_NONE,
            hit ? ASC_BAD_FIELD : ASC_NONE, ASCQ_NONE, !hit);
      end
      cmd(OPC_VERIFY10, 8'h00, $urandom, 0, 8'h00, SK_NONE, ASC_NONE, ASCQ_NONE, 0);
      cmd(OPC_VERIFY12, 8'h00, $urandom, 0, 8'h00, SK_NONE, ASC_NONE, ASCQ_NONE, 0);
      cmd(8'h00, 8'h00, $urandom, 1, 8'h00, SK_ILLEGAL, ASC_BAD_OPC, ASCQ_NONE, 0);
      foreach (bad_flags[i])
         cmd(i == 2 ? OPC_VERIFY12 : OPC_VERIFY10, bad_flags[i], $urandom, 1, i == 3 ? 8'h04 : 8'h00,
            SK_ILLEGAL, ASC_BAD_FIELD, ASCQ_NONE, 0);
      for (int i = 0; i < 6; i++) begin
         slow = 1'($urandom);
         a = 1 + $urandom % 3;
         hit = $urandom % 2;
         cmd(hit ? OPC_VERIFY12 : OPC_VERIFY10, 8'($urandom) & (hit ? 8'h1A : 8'h12), $urandom, a,
            8'h00, SK_NONE, ASC_NONE, ASCQ_NONE, a);
      end
      e_kind = 2'd1;
      a = $urandom;
      e_lba = a + 2;
      cmd(OPC_VERIFY10, 8'h00, a, 4, 8'h00, SK_MEDIUM, ASC_READ_ERR, ASCQ_NONE, 3);
      reg_rd(REG_STAT, r);
      chk(r, {8'h00, ASCQ_NONE, ASC_READ_ERR, SK_MEDIUM, 4'h2});
      cmd(OPC_VERIFY10, 8'h00, a + 3, 1, 8'h00, SK_NONE, ASC_NONE, ASCQ_NONE, 1);
      e_kind = 2'd0;
      e_lba = a + 1;
      bad_k = BLK + 1;
      cmd(OPC_VERIFY12, 8'h0A, a, 3, 8'h00, SK_MISCOMPARE, ASC_MISCOMPARE, ASCQ_NONE, 2);
      bad_k = -1;
      reg_wr(REG_CTRL, 32'h1);
      prot = 1'b1;
      reg_rd(REG_CTRL, r);
      chk(r, 32'h1);
      for (int kd = 2; kd < 4; kd++) for (int vp = 0; vp < 5; vp++) begin
         e_kind = 2'(kd);
         e_lba = $urandom;
         hit = (kd == 2) ? (vp inside {0, 1, 4}) : (vp inside {0, 1, 2});
         cmd(OPC_VERIFY10, 8'(vp << 5), e_lba, 1, 8'h00, hit ? SK_ABORTED : SK_NONE, hit ? ASC_PI :
            ASC_NONE, hit ? (kd == 2 ? ASCQ_GRD : ASCQ_REF) : ASCQ_NONE, 1);
      end
      cmd(OPC_VERIFY10, 8'hA0, $urandom, 1, 8'h00, SK_ILLEGAL, ASC_BAD_FIELD, ASCQ_NONE, 0);
      print_verdict();
   end
endmodule : svce_engine_tb
`default_nettype wire
